/* rtl/ddr_dev_pkg.sv */
package ddr_dev_pkg;
   // Command encoding {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;
   // Field positions
   localparam int DLL_RST_BIT = 8;
   localparam int DLL_EN_BIT = 0;
   localparam int AP_BIT = 10;
   localparam int BT_BIT = 3;
   // Reset values
   localparam logic [12:0] MODE_RST = 13'h0000;
   localparam logic [12:0] EMODE_RST = 13'h0001;
   localparam logic [12:0] REF_CNT_RST = 13'h0000;
   // Mode register select values on the bank address pins
   localparam logic [1:0] SEL_BASE = 2'h0;
   localparam logic [1:0] SEL_EXT = 2'h1;
   // Array geometry
   localparam int NUM_BANKS = 4;
   localparam int ROW_W = 13;
   localparam int COL_W = 4;
   localparam int DQ_W = 8;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int CK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int READ_LAT = 2;
   localparam int DLL_LOCK_CYC = 200;
   localparam int REF_NEEDED = 2;
endpackage

/* rtl/ddr_cdc_level.sv */
`timescale 1ns/1ns
`default_nettype none
module ddr_cdc_level
   import ddr_dev_pkg::*;
#(
   parameter int W = 1
) (
   // Destination domain
   input wire logic clk,
   input wire logic rst,
   // Level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1_r;
      logic [W-1:0] s2_r;
   } sync_s;
   sync_s st_r;
   sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1_r = d;
      st_nxt.s2_r = st_r.s1_r;
      if (rst) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign q = st_r.s2_r;
endmodule
`default_nettype wire

/* rtl/ddr_dev_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// [RQ1] Two data words move per clock at the pins, from a 2n prefetch
// [RQ2] Each access is one 2n core transfer split into two half-clock beats
// [RQ3] Array has four independent banks operating concurrently
// [RQ4] Active opens a row before read or write; burst follows mode
// [RQ5] Bank and row A0-A12 are sampled with the Active command
// [RQ6] Starting column is sampled with the Read or Write command
// [RQ7] Data and strobe stay high impedance except during a read
// [RQ8] Controller waits 200 us after power is stable before commands
// [RQ9] After the wait controller issues NOP and raises clock enable
// [RQ10] Controller then issues Precharge All before mode programming
// [RQ11] Extended mode load enables DLL, then base load resets DLL
// [RQ12] At least 200 clocks pass from DLL reset to any Read
// [RQ13] Controller issues another Precharge All, idling all banks
// [RQ14] Two auto refresh cycles are performed during initialization
// [RQ15] Final base mode load clears DLL reset; normal operation follows
// [RQ16] Mode loads in normal operation leave array contents intact
// [RQ17] Mode loads leave the refresh address counter unchanged
// [RQ18] Data mask is an input only and never driven
// [RQ19] Bank bits 00 select base mode, 01 select extended mode
// [RQ20] Base mode bit A8 is DLL reset, self clearing; others persist
// [RQ21] Extended mode bit A0 holds the DLL enable
// [RQ22] Only NOP or Deselect between init steps until waits elapse
module ddr_dev_core
   import ddr_dev_pkg::*;
#(
   parameter int BANKS = NUM_BANKS,
   parameter int ROWS_W = ROW_W,
   parameter int COLS_W = COL_W,
   parameter int DW = DQ_W
) (
   // System side
   input wire logic mclk,
   input wire logic rst,
   // Command pins, sampled on the link clock
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [12:0] addr,
   // Data pins, split into in, out and enable
   input wire logic [DW-1:0] dq_in,
   output logic [DW-1:0] dq_out,
   output logic dq_oe,
   input wire logic dqs_in,
   output logic dqs_out,
   output logic dqs_oe,
   input wire logic dm,
   // Status toward the system clock
   output logic ready,
   output logic dll_locked
);
   ////////////////////////////////////////////////////////////////////
   localparam int NW = 1 << (COLS_W - 1);
   localparam int CW = $clog2(DLL_LOCK_CYC + 1);

   typedef enum logic [2:0] {
      ST_PWR, ST_PRE1, ST_EMRS, ST_MRS1, ST_PRE2, ST_REF, ST_MRS2, ST_RUN
   } init_e;

   typedef logic [2*DW-1:0] word_t;

   typedef struct packed {
      init_e init;
      logic [12:0] mode;
      logic [12:0] emode;
      logic [12:0] ref_cnt;
      logic [1:0] ref_seen;
      logic [CW-1:0] lock_cnt;
      logic [BANKS-1:0] open;
      logic [BANKS-1:0][ROWS_W-1:0] row;
      logic rd_act;
      logic wr_act;
      logic [1:0] rd_bank;
      logic [1:0] wr_bank;
      logic [COLS_W-1:0] col;
      logic [COLS_W-1:0] start;
      logic [3:0] beats;
      logic [READ_LAT-1:0] rd_pipe;
      logic drive;
      logic wr_pend;
      logic [COLS_W-1:0] wr_col;
      logic ready;
      logic locked;
   } link_s;

   link_s st_r;
   link_s st_nxt;
   // Array storage: one 2n-bit word per column pair, rows share a page
   word_t mem_r [BANKS][NW];

   function automatic logic [3:0] burst_len(input logic [2:0] code);
      unique case (code)
         3'h1: burst_len = 4'h2;
         3'h2: burst_len = 4'h4;
         3'h3: burst_len = 4'h8;
         default: burst_len = 4'h2;
      endcase
   endfunction

   // Next column in a wrapped block, sequential or interleaved
   function automatic logic [COLS_W-1:0] next_col(
      input logic [COLS_W-1:0] base, input logic [COLS_W-1:0] cur,
      input logic [3:0] n, input logic [3:0] bl, input logic il);
      logic [COLS_W-1:0] msk;
      logic [COLS_W-1:0] off;
      msk = COLS_W'(bl - 4'h1);
      off = il ? (COLS_W'(n) ^ (base & msk))
               : ((base + COLS_W'(n)) & msk);
      next_col = (cur & ~msk) | (off & msk);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Reset comes from the system clock, so it is resynchronised to ck
   logic rst_ck;
   ddr_cdc_level #(.W(1)) u_rst_sync (
      .clk(ck),
      .rst(1'b0),
      .d(rst),
      .q(rst_ck)
   );

   logic [3:0] cmd;
   logic [2:0] bl_code;
   logic [3:0] bl;
   assign cmd = cke ? {cs_n, ras_n, cas_n, we_n} : CMD_NOP;
   assign bl_code = st_r.mode[2:0];
   assign bl = burst_len(bl_code);

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_pipe = {st_r.rd_pipe[READ_LAT-2:0], 1'b0};
      if (st_r.lock_cnt != '0) begin
         st_nxt.lock_cnt = st_r.lock_cnt - CW'(1);
      end
      st_nxt.locked = st_r.emode[DLL_EN_BIT] && st_r.lock_cnt == '0; // RQ21
      // Write commit trails the burst step by one ck
      st_nxt.wr_pend = st_r.wr_act; // RQ2
      st_nxt.wr_col = st_r.col;
      // Burst progress, one 2n word per clock
      if (st_r.rd_act || st_r.wr_act) begin // RQ2
         st_nxt.beats = st_r.beats + 4'h2;
         st_nxt.col = next_col(st_r.start, st_r.col,
            st_r.beats + 4'h2, bl, st_r.mode[BT_BIT]); // RQ4
         if (st_r.beats + 4'h2 >= bl) begin
            st_nxt.rd_act = 1'b0;
            st_nxt.wr_act = 1'b0;
         end
      end
      st_nxt.drive = st_r.rd_pipe[READ_LAT-1]; // RQ7
      unique case (cmd)
         CMD_MRS: begin
            if (ba == SEL_BASE) begin // RQ19
               st_nxt.mode = addr; // RQ16 RQ17
               if (addr[DLL_RST_BIT]) begin
                  st_nxt.lock_cnt = CW'(DLL_LOCK_CYC); // RQ12
               end
               st_nxt.mode[DLL_RST_BIT] = 1'b0; // RQ20
            end else if (ba == SEL_EXT) begin // RQ19
               st_nxt.emode = addr; // RQ21
            end
         end
         CMD_REF: begin
            st_nxt.ref_cnt = st_r.ref_cnt + 13'h0001;
            if (st_r.ref_seen != 2'h3) begin
               st_nxt.ref_seen = st_r.ref_seen + 2'h1;
            end
         end
         CMD_PRE: begin
            if (addr[AP_BIT]) begin
               st_nxt.open = '0;
            end else begin
               st_nxt.open[ba] = 1'b0;
            end
         end
         CMD_ACT: begin
            st_nxt.open[ba] = 1'b1; // RQ3
            st_nxt.row[ba] = addr[ROWS_W-1:0]; // RQ5
         end
         CMD_RD, CMD_WR: begin
            if (st_r.open[ba] && st_r.init == ST_RUN) begin // RQ4
               st_nxt.rd_act = cmd == CMD_RD && st_r.locked; // RQ12
               st_nxt.wr_act = cmd == CMD_WR;
               st_nxt.rd_bank = ba;
               st_nxt.wr_bank = ba;
               st_nxt.col = addr[COLS_W-1:0]; // RQ6
               st_nxt.start = addr[COLS_W-1:0];
               st_nxt.beats = 4'h0;
            end
         end
         default: begin
         end
      endcase
      st_nxt.rd_pipe[0] = st_nxt.rd_act; // RQ7
      // Initialization tracker follows what the controller issues
      unique case (st_r.init)
         ST_PWR: if (cmd == CMD_PRE) st_nxt.init = ST_PRE1; // RQ9 RQ10
         ST_PRE1: if (cmd == CMD_MRS && ba == SEL_EXT)
            st_nxt.init = ST_EMRS; // RQ11
         ST_EMRS: if (cmd == CMD_MRS && ba == SEL_BASE)
            st_nxt.init = ST_MRS1;
         ST_MRS1: if (cmd == CMD_PRE) st_nxt.init = ST_PRE2; // RQ13
         ST_PRE2: if (cmd == CMD_REF && st_r.ref_seen == 2'h1)
            st_nxt.init = ST_REF; // RQ14
         ST_REF: if (cmd == CMD_MRS && ba == SEL_BASE
            && !addr[DLL_RST_BIT]) st_nxt.init = ST_MRS2; // RQ15
         ST_MRS2: st_nxt.init = ST_RUN;
         ST_RUN: st_nxt.init = ST_RUN;
      endcase
      if (st_r.init == ST_PRE1) begin
         st_nxt.ref_seen = 2'h0;
      end
      st_nxt.ready = st_r.init == ST_RUN;
      if (rst_ck) begin
         st_nxt = '0;
         st_nxt.mode = MODE_RST;
         st_nxt.emode = EMODE_RST;
         st_nxt.ref_cnt = REF_CNT_RST;
         st_nxt.init = ST_PWR;
      end
   end

   always_ff @(posedge ck) begin
      st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // Write beats on the strobe: rising edge takes the first beat,
   // falling edge the second; both settle before the commit edge
   logic [DW-1:0] beat_a_r;
   logic [DW-1:0] beat_b_r;
   logic mask_a_r;
   logic mask_b_r;

   always_ff @(posedge dqs_in) begin
      beat_a_r <= dq_in; // RQ1
      mask_a_r <= dm; // RQ18
   end

   always_ff @(negedge dqs_in) begin
      beat_b_r <= dq_in; // RQ1
      mask_b_r <= dm; // RQ18
   end

   // Odd start column puts the first beat in the upper half
   always_ff @(posedge ck) begin
      if (st_r.wr_pend) begin // RQ2
         if (!(st_r.wr_col[0] ? mask_a_r : mask_b_r)) begin // RQ18
            mem_r[st_r.wr_bank][st_r.wr_col[COLS_W-1:1]][2*DW-1:DW] <=
               st_r.wr_col[0] ? beat_a_r : beat_b_r;
         end
         if (!(st_r.wr_col[0] ? mask_b_r : mask_a_r)) begin // RQ18
            mem_r[st_r.wr_bank][st_r.wr_col[COLS_W-1:1]][DW-1:0] <=
               st_r.wr_col[0] ? beat_b_r : beat_a_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read: core word fetched, sent as two half-clock beats.
   // Limitation: odd sequential starts beyond two beats are not exact
   word_t rd_word_r;
   logic rd_swap_r;
   logic [DW-1:0] beat_hold_r;

   always_ff @(posedge ck) begin
      if (st_r.rd_act) begin
         rd_word_r <= mem_r[st_r.rd_bank][st_r.col[COLS_W-1:1]]; // RQ2
         rd_swap_r <= st_r.col[0]; // RQ6
      end
   end

   // Second beat is held so a following fetch cannot disturb it
   always_ff @(posedge ck or negedge ck) begin
      if (ck) begin
         dq_out <= rd_swap_r ? rd_word_r[2*DW-1:DW] : rd_word_r[DW-1:0];
         beat_hold_r <= rd_swap_r ? rd_word_r[DW-1:0]
                                  : rd_word_r[2*DW-1:DW]; // RQ1
         dqs_out <= st_r.rd_pipe[READ_LAT-1];
         dq_oe <= st_r.rd_pipe[READ_LAT-1]; // RQ7
         dqs_oe <= st_r.rd_pipe[READ_LAT-1]; // RQ7
      end else begin
         dq_out <= beat_hold_r; // RQ1
         dqs_out <= 1'b0;
         dq_oe <= st_r.drive; // RQ7
         dqs_oe <= st_r.drive; // RQ7
      end
   end

   ddr_cdc_level #(.W(2)) u_stat_sync (
      .clk(mclk),
      .rst(rst),
      .d({st_r.ready, st_r.locked}),
      .q({ready, dll_locked})
   );

   ////////////////////////////////////////////////////////////////////
   // Read accepted: open bank, normal operation, DLL settled, no burst
   sequence seq_rd_taken;
      cmd == CMD_RD && st_r.open[ba] && st_r.init == ST_RUN
         && st_r.locked && !st_r.rd_act;
   endsequence
   sequence seq_rd_out;
      ##2 (dq_oe && dqs_oe);
   endsequence
   sequence seq_rd_closed;
      cmd == CMD_RD && !st_r.open[ba] && !st_r.rd_act;
   endsequence

   AST_DLL_SELFCLR: assert property (@(posedge ck) disable iff (rst_ck) // RQ20
      !st_r.mode[DLL_RST_BIT]) else $error("dll reset bit stuck");
   AST_DQ_Z: assert property (@(posedge ck) disable iff (rst_ck) // RQ7
      st_r.init != ST_RUN |-> !dq_oe && !dqs_oe)
      else $error("data driven before normal operation");
   AST_RD_DRIVE: assert property (@(posedge ck) disable iff (rst_ck) // RQ7
      seq_rd_taken |=> seq_rd_out) else $error("read data not driven");
   AST_RD_CLOSED: assert property (@(posedge ck) disable iff (rst_ck) // RQ4
      seq_rd_closed |=> !st_r.rd_act) else $error("closed bank read");
   AST_ACT_ROW: assert property (@(posedge ck) disable iff (rst_ck) // RQ5
      cmd == CMD_ACT |=> st_r.open[$past(ba)]
         && st_r.row[$past(ba)] == $past(addr[ROWS_W-1:0]))
      else $error("row not opened");
   AST_MRS_REFCNT: assert property (@(posedge ck) disable iff (rst_ck) // RQ17
      cmd == CMD_MRS |=> st_r.ref_cnt == $past(st_r.ref_cnt))
      else $error("refresh counter moved");
   AST_EMRS_SEL: assert property (@(posedge ck) disable iff (rst_ck) // RQ19
      cmd == CMD_MRS && ba == SEL_EXT |=> st_r.emode == $past(addr))
      else $error("extended mode not loaded");
   AST_LOCK_WAIT: assert property (@(posedge ck) disable iff (rst_ck) // RQ12
      cmd == CMD_MRS && ba == SEL_BASE && addr[DLL_RST_BIT]
      |=> ##1 !st_r.locked) else $error("lock flagged early");
   AST_PRE_ALL: assert property (@(posedge ck) disable iff (rst_ck) // RQ3
      cmd == CMD_PRE && addr[AP_BIT] |=> st_r.open == '0)
      else $error("bank left open");
endmodule
`default_nettype wire

/* tb/ddr_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ddr_ctrl_model
   import ddr_dev_pkg::*;
#(
   // 200 us at a 32 ns link clock
   parameter int INIT_WAIT_CK = 6250
) (
   // Link clock
   input wire logic ck,
   // Command pins
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] ba,
   output logic [12:0] addr,
   // Write data side
   output logic [DQ_W-1:0] dq_in,
   output logic dqs_in,
   output logic dm
);
   initial begin
      cke = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
      ba = 2'h0;
      addr = 13'h0000;
      dq_in = 8'h5A;
      dqs_in = 1'b0;
      dm = 1'b0;
   end
   ////////////////////////////////////////
   // Command held over one rising edge, NOP after
   task automatic cmd(input logic [3:0] c, input logic [1:0] b,
      input logic [12:0] a);
      @(posedge ck);
      {cs_n, ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      @(posedge ck);
      {cs_n, ras_n, cas_n, we_n} <= CMD_NOP;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge ck);
   endtask
   task automatic init_a();
      idle(INIT_WAIT_CK);
      cke <= 1'b1;
      cmd(CMD_NOP, 2'h0, 13'h0000);
      cmd(CMD_PRE, 2'h0, 13'h0400);
      cmd(CMD_MRS, SEL_EXT, EMODE_RST);
      cmd(CMD_MRS, SEL_BASE, 13'h0121);
   endtask
   task automatic init_b();
      idle(DLL_LOCK_CYC);
      cmd(CMD_PRE, 2'h0, 13'h0400);
      cmd(CMD_REF, 2'h0, 13'h0000);
      cmd(CMD_REF, 2'h0, 13'h0000);
      cmd(CMD_MRS, SEL_BASE, 13'h0021);
   endtask
   ////////////////////////////////////////
   // Strobe edges sit in the middle of each beat
   task automatic wr(input logic [1:0] b, input logic [3:0] c,
      input logic [7:0] d0, input logic [7:0] d1);
      cmd(CMD_WR, b, {9'h000, c});
      dq_in <= d0;
      @(negedge ck);
      dqs_in <= 1'b1;
      @(posedge ck);
      dq_in <= d1;
      @(negedge ck);
      dqs_in <= 1'b0;
      @(posedge ck);
      dq_in <= ~d1; // Released bus must not keep the last beat
   endtask
endmodule
`default_nettype wire

/* tb/test_ddr_sdram_init_and_access.sv */
`timescale 1ns/1ns
`default_nettype none
module test_ddr_sdram_init_and_access
   import ddr_dev_pkg::*;
;
   logic mclk, rst, ck, cke, cs_n, ras_n, cas_n, we_n, dqs_in, dm;
   logic dq_oe, dqs_out, dqs_oe, ready, dll_locked;
   logic [1:0] ba;
   logic [12:0] addr;
   logic [DQ_W-1:0] dq_in, dq_out;
   int num_errors = 0;
   int total_checks = 0;
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Odd offset keeps the link clock out of phase
   initial begin
      ck = 1'b0;
      #7;
      forever #16 ck = ~ck;
   end
   ddr_ctrl_model ctrl_u (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
      .dqs_in(dqs_in), .dm(dm));
   ddr_dev_core dut_u (.mclk(mclk), .rst(rst), .ck(ck), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dm(dm),
      .ready(ready), .dll_locked(dll_locked));
   ////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic rd(input logic [1:0] b, input logic [3:0] c,
      input logic [7:0] d0, input logic [7:0] d1);
      ctrl_u.cmd(CMD_RD, b, {9'h000, c});
      repeat (READ_LAT) @(posedge ck);
      #4;
      check(8'({dq_oe, dqs_oe}), 8'h03);
      check(dq_out, d0);
      @(negedge ck);
      #4;
      check(dq_out, d1);
      ctrl_u.idle(3);
      #4;
      check(8'({dq_oe, dqs_oe}), 8'h00);
   endtask
   ////////////////////////////////////////
   task automatic bring_up();
      check(8'({dq_oe, dqs_oe, ready}), 8'h00);
      ctrl_u.init_a();
      ctrl_u.idle(20);
      check(8'(dll_locked), 8'h00);
      ctrl_u.init_b();
      for (int i = 0; i < 400 && ready !== 1'b1; i++) begin
         @(posedge mclk);
      end
      check(8'({ready, dll_locked}), 8'h03);
      if (ready !== 1'b1) begin
         results();
      end
   endtask
   // Two banks open at once, odd start column wraps within the pair
   task automatic banks();
      ctrl_u.cmd(CMD_ACT, 2'h1, 13'h1ABC);
      ctrl_u.cmd(CMD_ACT, 2'h2, 13'h0055);
      ctrl_u.wr(2'h1, 4'h6, 8'hA1, 8'hB2);
      ctrl_u.wr(2'h2, 4'h6, 8'hC3, 8'hD4);
      rd(2'h1, 4'h7, 8'hB2, 8'hA1);
      rd(2'h2, 4'h6, 8'hC3, 8'hD4);
   endtask
   // Closed bank read is refused; mode reloads keep the array
   task automatic mode_reload();
      ctrl_u.cmd(CMD_PRE, 2'h0, 13'h0400);
      ctrl_u.cmd(CMD_RD, 2'h3, 13'h0000);
      repeat (READ_LAT) @(posedge ck);
      #4;
      check(8'(dq_oe), 8'h00);
      ctrl_u.cmd(CMD_MRS, SEL_EXT, EMODE_RST);
      ctrl_u.cmd(CMD_MRS, SEL_BASE, 13'h0021);
      ctrl_u.cmd(CMD_ACT, 2'h2, 13'h0055);
      rd(2'h2, 4'h6, 8'hC3, 8'hD4);
   endtask
   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      bring_up();
      banks();
      mode_reload();
      results();
   end
endmodule
`default_nettype wire
